// ===== src/hprl_pkg.sv
// Notes on behaviour
// - mode pin high selects boundary-scan test port, low selects host port.
// - all serial bits shift in and out on the shared serial clock.
// - in test mode the serial input pin is test data in.
// - in host mode register read data leaves on the serial output pin.
// - in test mode the serial output pin is test data out.
// - in host mode the select pin is an active-low chip select.
// - in test mode the select pin is test mode select, active high.
// - host-mode reset defaults state, floats pins, drives pixel clocks low.
// - host mode resumes normal operation when reset goes high.
// - test-mode reset defaults state and holds the scan sequence in reset.
// - test mode lets the scan sequence resume when reset goes high.
// - lock-select low and reference locked gives lock mode, outputs follow.
// - lock-select high makes video clock and timing free-run.
// - audio clocks stay locked to the video clock regardless of lock-select.
package hprl_pkg;
  localparam int unsigned CLK_PERIOD_NS    = 25;
  localparam int unsigned RESET_HOLD_US    = 500;
  localparam int unsigned RESET_HOLD_CYC   =
    (RESET_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DATA_W           = 16;
  localparam int unsigned ADDR_W           = 8;
  localparam int unsigned SCAN_W           = 8;
  localparam logic [3:0]  SCAN_IR_BYPASS   = 4'hf;
  localparam logic [3:0]  SCAN_IR_SAMPLE   = 4'h1;
  localparam logic [3:0]  SCAN_IR_RESET    = 4'hf;

  typedef enum logic [1:0] {
    HPRL_MODE_HOST,
    HPRL_MODE_TEST
  } hprl_mode_t;

  typedef enum logic [1:0] {
    HPRL_CLK_FREE,
    HPRL_CLK_WAIT_LOCK,
    HPRL_CLK_LOCKED
  } hprl_clk_t;

  // pins after synchronisation
  typedef struct packed {
    logic sclk;
    logic ser_in;
    logic sel;
    logic mode;
    logic lock_sel;
  } hprl_pins_t;

  // user-side register write strobe
  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } hprl_wr_t;
endpackage : hprl_pkg

// ===== src/hprl_top.sv
`timescale 1ns/1ps
`default_nettype none
module hprl_top #(
  parameter int unsigned HOLD_CYC = hprl_pkg::RESET_HOLD_CYC
) (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          mode_pin,
  input  wire logic                          serial_clock_shared_pin,
  input  wire logic                          serial_in_shared_pin,
  input  wire logic                          select_shared_pin,
  input  wire logic                          lock_select_pin,
  input  wire logic                          ref_locked,
  input  wire logic [hprl_pkg::DATA_W-1:0]   rd_data,
  output logic                               serial_out_shared_pin,
  output logic                               serial_out_oe_n,
  output logic                               pixel_clock_out_a,
  output logic                               pixel_clock_out_b,
  output logic                               pixel_oe_n,
  output hprl_pkg::hprl_wr_t                 wr,
  output logic [hprl_pkg::ADDR_W-1:0]        rd_addr,
  output logic                               video_follow_ref,
  output logic                               audio_follow_video,
  output logic                               scan_in_reset,
  output logic                               hold_done
);
  import hprl_pkg::*;

  logic       rst_meta;
  logic       rst_sync_n;
  hprl_pins_t meta;
  hprl_pins_t pin;
  logic       sclk_d;
  logic       rise;
  logic       fall;
  logic [31:0] hold_cnt;
  logic [4:0]  bit_cnt;
  logic [ADDR_W+DATA_W-1:0] shreg;
  logic [DATA_W-1:0]        out_sh;
  logic [SCAN_W-1:0]        scan_sh;
  logic [3:0]               tap;
  logic                     tdo;
  logic                     host_do;
  logic                     in_test;
  logic                     host_cs;
  hprl_clk_t                cstate;
  logic                     pclk_div;
  logic                     load_rd;

  // async assert, sync release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // pins come from outside; two stages, only stage two is read
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      meta <= '0;
      pin  <= '0;
    end else begin
      meta <= '{serial_clock_shared_pin, serial_in_shared_pin,
                select_shared_pin, mode_pin, lock_select_pin};
      pin  <= meta;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) sclk_d <= 1'b0;
    else             sclk_d <= pin.sclk;
  end
  assign rise = pin.sclk & ~sclk_d;
  assign fall = ~pin.sclk & sclk_d;

  assign in_test = pin.mode;
  assign host_cs = ~in_test & ~pin.sel;

  // device only counts the hold; honouring it is the reset source's job
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) hold_cnt <= '0;
    else if (hold_cnt < HOLD_CYC) hold_cnt <= hold_cnt + 32'h1;
  end
  assign hold_done = (hold_cnt >= HOLD_CYC);

  // host shift: address then data, msb first, on rising edges
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bit_cnt <= '0;
      shreg   <= '0;
      wr      <= '0;
      rd_addr <= '0;
    end else begin
      wr.valid <= 1'b0;
      if (!host_cs) begin
        bit_cnt <= '0;
      end else if (rise) begin
        shreg <= {shreg[ADDR_W+DATA_W-2:0], pin.ser_in};
        if (bit_cnt == 5'(ADDR_W - 1))
          rd_addr <= {shreg[ADDR_W-2:0], pin.ser_in};
        if (bit_cnt == 5'(ADDR_W + DATA_W - 1)) begin
          wr.valid <= 1'b1;
          wr.addr  <= shreg[ADDR_W+DATA_W-2:DATA_W-1];
          wr.data  <= {shreg[DATA_W-2:0], pin.ser_in};
          bit_cnt  <= '0;
        end else begin
          bit_cnt <= bit_cnt + 5'h1;
        end
      end
    end
  end

  // load a cycle after the address lands, so rd_data matches the new address
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) load_rd <= 1'b0;
    else             load_rd <= host_cs & rise & (bit_cnt == 5'(ADDR_W - 1));
  end

  // msb stands through the first data bit; shifting starts after its rise
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      out_sh <= '0;
    end else if (load_rd) begin
      out_sh <= rd_data;
    end else if (host_cs && fall && bit_cnt > 5'(ADDR_W)) begin
      out_sh <= {out_sh[DATA_W-2:0], 1'b0};
    end
  end
  assign host_do = out_sh[DATA_W-1];

  // minimal scan port: tms walks a small state counter, data path is a chain
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tap     <= SCAN_IR_RESET;
      scan_sh <= '0;
      tdo     <= 1'b0;
    end else if (in_test && rise) begin
      // active-high select walks state; all ones is test reset
      if (pin.sel) tap <= (tap == SCAN_IR_RESET) ? tap : tap + 4'h1;
      else         tap <= SCAN_IR_SAMPLE;
      if (!pin.sel) scan_sh <= {scan_sh[SCAN_W-2:0], pin.ser_in};
    end else if (in_test && fall) begin
      tdo <= scan_sh[SCAN_W-1];
    end
  end
  assign scan_in_reset = (tap == SCAN_IR_RESET);

  assign serial_out_shared_pin = in_test ? tdo : host_do;
  // pins float during reset and while host port is idle
  assign serial_out_oe_n = ~rst_sync_n | (~in_test & ~host_cs);

  // reference lock control
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cstate <= HPRL_CLK_FREE;
    end else begin
      case (cstate)
        HPRL_CLK_FREE:      if (!pin.lock_sel) cstate <= HPRL_CLK_WAIT_LOCK;
        HPRL_CLK_WAIT_LOCK: if (pin.lock_sel)  cstate <= HPRL_CLK_FREE;
                            else if (ref_locked) cstate <= HPRL_CLK_LOCKED;
        HPRL_CLK_LOCKED:    if (pin.lock_sel)  cstate <= HPRL_CLK_FREE;
                            else if (!ref_locked) cstate <= HPRL_CLK_WAIT_LOCK;
        default:            cstate <= HPRL_CLK_FREE;
      endcase
    end
  end
  assign video_follow_ref   = (cstate == HPRL_CLK_LOCKED);
  assign audio_follow_video = rst_sync_n;

  // stand-in pixel clock, held low in reset
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) pclk_div <= 1'b0;
    else             pclk_div <= ~pclk_div;
  end
  assign pixel_clock_out_a = pclk_div;
  assign pixel_clock_out_b = pclk_div;
  assign pixel_oe_n        = 1'b0;

  property p_rst_pclk_low;
    @(posedge clk) !rst_sync_n |-> !pixel_clock_out_a && !pixel_clock_out_b;
  endproperty
  a_rst_pclk_low: assert property (p_rst_pclk_low)
    else $error("pixel clock not low in reset");

  property p_rst_float;
    @(posedge clk) !rst_sync_n |-> serial_out_oe_n;
  endproperty
  a_rst_float: assert property (p_rst_float)
    else $error("serial out driven in reset");

  property p_resume;
    @(posedge clk) disable iff (!rst_sync_n)
      $rose(rst_sync_n) |=> pixel_clock_out_a;
  endproperty
  a_resume: assert property (p_resume)
    else $error("pixel clock did not resume");

  property p_free;
    @(posedge clk) disable iff (!rst_sync_n)
      pin.lock_sel |=> !video_follow_ref;
  endproperty
  a_free: assert property (p_free)
    else $error("following reference in free-run");

  property p_lock;
    @(posedge clk) disable iff (!rst_sync_n)
      video_follow_ref |-> $past(ref_locked);
  endproperty
  a_lock: assert property (p_lock)
    else $error("locked without reference");

  property p_audio;
    @(posedge clk) disable iff (!rst_sync_n) audio_follow_video;
  endproperty
  a_audio: assert property (p_audio)
    else $error("audio not following video");

  property p_host_oe;
    @(posedge clk) disable iff (!rst_sync_n)
      (!in_test && pin.sel) |-> serial_out_oe_n;
  endproperty
  a_host_oe: assert property (p_host_oe)
    else $error("driven while deselected");

  property p_test_out;
    @(posedge clk) disable iff (!rst_sync_n)
      in_test && fall |=>
        !in_test || serial_out_shared_pin == $past(scan_sh[SCAN_W-1]);
  endproperty
  a_test_out: assert property (p_test_out)
    else $error("test data out not on pin");

  sequence s_rst_hold;
    !rst_sync_n;
  endsequence
  property p_scan_rst;
    @(posedge clk) s_rst_hold |=> scan_in_reset;
  endproperty
  a_scan_rst: assert property (p_scan_rst)
    else $error("scan not in reset after reset");
endmodule : hprl_top
`default_nettype wire

// ===== tb/hprl_host.sv
`timescale 1ns/1ps
`default_nettype none
module hprl_host (
  input  wire logic clk,
  input  wire logic sout,
  output logic      sclk,
  output logic      sin,
  output logic      sel
);
  initial begin
    sclk = 1'b0;
    sin  = 1'b0;
    sel  = 1'b1;
  end
  // one serial period is 8 clk; the serial clock rests low between frames
  task automatic tick(input logic s, input logic d, output logic o);
    sel = s;
    sin = d;
    repeat (4) @(negedge clk);
    sclk = 1'b1;
    repeat (4) @(negedge clk);
    o    = sout;
    sclk = 1'b0;
  endtask : tick
  // n below 24 gives a cut-short frame
  task automatic frame(input logic [23:0] b, input int n,
                       output logic [15:0] rd);
    logic o;
    for (int i = 23; i > 23 - n; i--) begin
      tick(1'b0, b[i], o);
      if (i < 16) rd[i] = o;
    end
    repeat (4) @(negedge clk);
    sel = 1'b1;
    sin = ~sin; // a released line must not look like held data
  endtask : frame
endmodule : hprl_host
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import hprl_pkg::*;
  localparam int unsigned HOLD = 16;
  logic              clk, rst_n, mode_pin, lock_select_pin, ref_locked;
  logic              sclk, sin, sel, sout, oe_n, pa, pb, vfr, afv, sir, hd;
  logic              poe_n, line;
  logic [ADDR_W-1:0] rd_addr;
  hprl_wr_t          wr;
  hprl_wr_t          last_wr;
  int                n_mismatch, comparisons, n_wr, cyc;
  hprl_top #(.HOLD_CYC(HOLD)) hprl_top_i (
    .clk(clk), .rst_n(rst_n), .mode_pin(mode_pin),
    .serial_clock_shared_pin(sclk), .serial_in_shared_pin(sin),
    .select_shared_pin(sel), .lock_select_pin(lock_select_pin),
    .ref_locked(ref_locked), .rd_data({8'ha5, rd_addr}),
    .serial_out_shared_pin(sout), .serial_out_oe_n(oe_n),
    .pixel_clock_out_a(pa), .pixel_clock_out_b(pb), .pixel_oe_n(poe_n),
    .wr(wr), .rd_addr(rd_addr), .video_follow_ref(vfr),
    .audio_follow_video(afv), .scan_in_reset(sir), .hold_done(hd));
  hprl_host hprl_host_i (.clk(clk), .sout(line), .sclk(sclk), .sin(sin),
    .sel(sel));
  // a released pin reads back inverted, so a stale bit cannot pass
  assign line = oe_n ? ~sout : sout;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string w, input logic [23:0] e,
                     input logic [23:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask : chk
  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  // the timeout also guards every bounded wait below
  always @(posedge clk) begin
    cyc++;
    if (wr.valid === 1'b1) begin
      n_wr++;
      last_wr = wr;
    end
    if (cyc > 20000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic reset_in(input logic m);
    @(negedge clk);
    rst_n    = 1'b0;
    mode_pin = m;
    repeat (2) @(negedge clk);
    chk("pix_a", 24'h0, {23'h0, pa});
    chk("pix_b", 24'h0, {23'h0, pb});
    chk("oe_n", 24'h1, {23'h0, oe_n});
    chk("scan_rst", 24'h1, {23'h0, sir});
    chk("pix_oe", 24'h0, {23'h0, poe_n});
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask : reset_in
  task automatic t_start;
    logic p;
    chk("hold_early", 24'h0, {23'h0, hd});
    p = pa;
    @(negedge clk);
    chk("pix_runs", {23'h0, ~p}, {23'h0, pa});
    chk("pix_b_runs", {23'h0, ~p}, {23'h0, pb});
    repeat (HOLD) @(negedge clk);
    chk("hold_done", 24'h1, {23'h0, hd});
    chk("audio", 24'h1, {23'h0, afv});
    $display("done start");
  endtask : t_start
  task automatic t_frames;
    logic [15:0] rd;
    logic [23:0] f [2] = '{24'h3cc35a, 24'hc35aa5};
    foreach (f[k]) begin
      n_wr = 0;
      hprl_host_i.frame(f[k], 24, rd);
      chk("wr_count", 24'h1, n_wr[23:0]);
      chk("wr", f[k], {last_wr.addr, last_wr.data});
      chk("rd", {8'h0, 8'ha5, f[k][23:16]}, {8'h0, rd});
      repeat (8) @(negedge clk);
      chk("oe_idle", 24'h1, {23'h0, oe_n});
    end
    n_wr = 0;
    hprl_host_i.frame(24'h123456, 10, rd);
    repeat (8) @(negedge clk);
    chk("partial", 24'h0, n_wr[23:0]);
    $display("done frames");
  endtask : t_frames
  task automatic t_scan;
    logic [7:0] got;
    logic [7:0] pat = 8'hb4;
    logic       o;
    reset_in(1'b1);
    hprl_host_i.tick(1'b0, 1'b0, o);
    chk("scan_run", 24'h0, {23'h0, sir});
    for (int i = 7; i >= 0; i--) hprl_host_i.tick(1'b0, pat[i], o);
    for (int i = 7; i >= 0; i--) begin
      hprl_host_i.tick(1'b0, 1'b0, o);
      got[i] = o;
    end
    chk("scan_out", 24'h0000b4, {16'h0, got});
    // select high walks one step per rise from sample towards reset
    repeat (int'(SCAN_IR_RESET - SCAN_IR_SAMPLE) - 1)
      hprl_host_i.tick(1'b1, 1'b0, o);
    chk("scan_walk", 24'h0, {23'h0, sir});
    hprl_host_i.tick(1'b1, 1'b0, o);
    chk("scan_sel", 24'h1, {23'h0, sir});
    reset_in(1'b0);
    $display("done scan");
  endtask : t_scan
  task automatic wait_vfr(input logic v);
    for (int i = 0; i < 20 && vfr !== v; i++) @(negedge clk);
  endtask : wait_vfr
  task automatic t_lock;
    ref_locked      = 1'b1; // reference first
    lock_select_pin = 1'b0;
    wait_vfr(1'b1);
    chk("locked", 24'h1, {23'h0, vfr});
    ref_locked = 1'b0;
    wait_vfr(1'b0);
    chk("ref_lost", 24'h0, {23'h0, vfr});
    ref_locked = 1'b1;
    wait_vfr(1'b1);
    lock_select_pin = 1'b1;
    wait_vfr(1'b0);
    chk("free_run", 24'h0, {23'h0, vfr});
    chk("audio_lock", 24'h1, {23'h0, afv});
    $display("done lock");
  endtask : t_lock
  initial begin
    rst_n           = 1'b0;
    mode_pin        = 1'b0;
    lock_select_pin = 1'b1;
    ref_locked      = 1'b0;
    reset_in(1'b0);
    t_start();
    t_frames();
    t_scan();
    t_frames();
    t_lock();
    finish_test();
  end
endmodule : tb
`default_nettype wire
